//--- design/bus_release_pkg.sv
// constants and types for the external bus release arbiter
//
// Functional notes
// - sample request one state before cycle end
// - release after cycle where request seen
// - missed sample point: finish next cycle too
// - grant about 1.5 states after group end
// - never release inside one bus cycle
// - test-and-set read and write stay together
// - refresh plus following cycle stay together
// - refresh at grant time keeps grant negated
// - priority: refresh, external, transfer, processor
// - refresh due while granted negates grant
package bus_release_pkg;

    localparam int GRANT_DELAY_HALF_STATES = 3;
    localparam logic [1:0] GRANT_DELAY_CYCLES = 2'h1;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_OWNCYC  = 5'h02,
        ST_HANDOFF = 5'h04,
        ST_GRANTED = 5'h08,
        ST_RECLAIM = 5'h10
    } arb_state_t;

    typedef enum logic [1:0] {
        OWN_CPU  = 2'h0,
        OWN_XFER = 2'h1,
        OWN_REFR = 2'h2,
        OWN_EXT  = 2'h3
    } owner_t;

endpackage : bus_release_pkg

//--- design/external_bus_release_arbiter.sv
// arbiter handing the external bus to an outside master
`timescale 1ns/1ps
module external_bus_release_arbiter
    import bus_release_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic bus_request_in_n_i,
    input  wire logic refresh_req_i,
    input  wire logic xfer_req_i,
    input  wire logic cpu_req_i,
    input  wire logic cycle_last_state_i,
    input  wire logic cycle_end_i,
    input  wire logic group_hold_i,
    output logic      bus_grant_n_o,
    output logic      bus_drive_oe_n_o,
    output logic      start_refresh_o,
    output logic      start_xfer_o,
    output logic      start_cpu_o,
    output owner_t    owner_o
);
    // inputs from the core: cycle_last_state_i marks the state one before
    // the cycle end; group_hold_i is high for a sub-access and for the read
    // half of test-and-set; refresh_hold keeps a refresh with its next cycle

    logic       req_s1;
    logic       req_s2;
    logic       req_s3;
    logic       req_seen;
    logic       release_pending;
    logic       in_cycle;
    logic       refresh_hold;
    logic [1:0] grant_cnt;
    arb_state_t state;
    arb_state_t next_state;

    // three stages: a pin change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            req_seen <= 1'b0;
        end else begin
            req_s1 <= ~bus_request_in_n_i;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            if (req_s2 == req_s3) begin
                req_seen <= req_s3;
            end
        end
    end

    // a cycle is running from a start pulse to its end strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_cycle <= 1'b0;
        end else if (start_refresh_o || start_xfer_o || start_cpu_o) begin
            in_cycle <= 1'b1;
        end else if (cycle_end_i) begin
            in_cycle <= 1'b0;
        end
    end

    // request latched only at the sample point, one state before the end;
    // a late request waits for the next cycle's sample point
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            release_pending <= 1'b0;
        end else if (state == ST_GRANTED) begin
            release_pending <= 1'b0;
        end else if (in_cycle && cycle_last_state_i && req_seen) begin
            release_pending <= 1'b1;
        end else if (!req_seen) begin
            release_pending <= 1'b0;
        end
    end

    // high while a refresh cycle runs: its end must chain straight into
    // the next cycle, or an idle gap would let the bus go mid-group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refresh_hold <= 1'b0;
        end else if (start_refresh_o) begin
            refresh_hold <= 1'b1;
        end else if (start_xfer_o || start_cpu_o) begin
            refresh_hold <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (req_seen && !refresh_req_i) begin
                    next_state = ST_HANDOFF;
                end else if (refresh_req_i || xfer_req_i || cpu_req_i) begin
                    next_state = ST_OWNCYC;
                end
            end
            ST_OWNCYC: begin
                // no release inside a cycle, a test-and-set pair or a
                // refresh group
                if (cycle_end_i && !group_hold_i && !refresh_hold
                    && release_pending) begin
                    next_state = ST_HANDOFF;
                end else if (cycle_end_i && !group_hold_i && !refresh_hold) begin
                    next_state = ST_IDLE;
                end
            end
            ST_HANDOFF: begin
                // a refresh landing here cancels the grant
                if (refresh_req_i) begin
                    next_state = ST_IDLE;
                end else if (grant_cnt == GRANT_DELAY_CYCLES) begin
                    next_state = ST_GRANTED;
                end
            end
            ST_GRANTED: begin
                if (refresh_req_i || !req_seen) begin
                    next_state = ST_RECLAIM;
                end
            end
            ST_RECLAIM: begin
                // outside master keeps the bus until it drops its request
                if (!req_seen) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // 1.5 states rounded to whole cycles: one wait plus the grant flop
    always_ff @(posedge clk_i) begin
        if (rst_i || state != ST_HANDOFF) begin
            grant_cnt <= 2'h0;
        end else begin
            grant_cnt <= grant_cnt + 2'h1;
        end
    end

    // grant from one flop so the pin never glitches from this logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_grant_n_o <= 1'b1;
        end else begin
            bus_grant_n_o <= !(next_state == ST_GRANTED);
        end
    end

    // drivers stay off while granted or reclaiming
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_drive_oe_n_o <= 1'b0;
        end else begin
            bus_drive_oe_n_o <= (next_state == ST_GRANTED)
                             || (next_state == ST_RECLAIM)
                             || (next_state == ST_HANDOFF
                                 && grant_cnt == GRANT_DELAY_CYCLES);
        end
    end

    // start pulses by priority when idle, or chained at a held cycle end
    always_comb begin
        start_refresh_o = 1'b0;
        start_xfer_o = 1'b0;
        start_cpu_o = 1'b0;
        if (state == ST_IDLE && next_state == ST_OWNCYC) begin
            if (refresh_req_i) begin
                start_refresh_o = 1'b1;
            end else if (xfer_req_i) begin
                start_xfer_o = 1'b1;
            end else begin
                start_cpu_o = 1'b1;
            end
        end else if (state == ST_OWNCYC && cycle_end_i
                     && (group_hold_i || refresh_hold)) begin
            start_xfer_o = xfer_req_i;
            start_cpu_o = !xfer_req_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            owner_o <= OWN_CPU;
        end else if (next_state == ST_GRANTED) begin
            owner_o <= OWN_EXT;
        end else if (start_refresh_o) begin
            owner_o <= OWN_REFR;
        end else if (start_xfer_o) begin
            owner_o <= OWN_XFER;
        end else if (start_cpu_o || next_state == ST_IDLE) begin
            owner_o <= OWN_CPU;
        end
    end

endmodule : external_bus_release_arbiter

//--- tb/bus_release_props.sv
// assertions on the ports of the bus release arbiter
`timescale 1ns/1ps
module bus_release_props
    import bus_release_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus_request_in_n_i,
    input wire logic refresh_req_i,
    input wire logic xfer_req_i,
    input wire logic cycle_end_i,
    input wire logic group_hold_i,
    input wire logic bus_grant_n_o,
    input wire logic bus_drive_oe_n_o,
    input wire logic start_refresh_o,
    input wire logic start_xfer_o,
    input wire logic start_cpu_o,
    input wire owner_t owner_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_pins_released: assert property (!bus_grant_n_o |-> bus_drive_oe_n_o)
        else $error("bus driven while granted");
    a_owner_is_ext: assert property (!bus_grant_n_o |-> owner_o == OWN_EXT)
        else $error("owner wrong while granted");
    a_refresh_drops: assert property (refresh_req_i && !bus_grant_n_o |=> bus_grant_n_o)
        else $error("grant kept during refresh");
    a_no_group_break: assert property ($fell(bus_grant_n_o) |-> !$past(cycle_end_i && group_hold_i, 3))
        else $error("grant inside a group");
    a_req_before: assert property ($fell(bus_grant_n_o) |-> !$past(bus_request_in_n_i, 3))
        else $error("grant without request");
    a_grant_stands: assert property (!bus_grant_n_o && !bus_request_in_n_i && !refresh_req_i |=> !bus_grant_n_o)
        else $error("grant dropped early");
    a_start_onehot: assert property ($onehot0({start_refresh_o, start_xfer_o, start_cpu_o}))
        else $error("two starts at once");
    a_refresh_first: assert property (start_xfer_o || start_cpu_o |-> !refresh_req_i)
        else $error("refresh passed over");
    a_xfer_over_cpu: assert property (start_cpu_o |-> !xfer_req_i)
        else $error("transfer passed over");
    c_grant: cover property ($fell(bus_grant_n_o));
    c_refresh_grant: cover property (refresh_req_i && !bus_grant_n_o);
    c_refresh_start: cover property (start_refresh_o);
endmodule : bus_release_props
bind external_bus_release_arbiter bus_release_props u_props (.*);

//--- tb/ext_master_model.sv
// outside bus master: asks for the bus, yields when grant goes away
`timescale 1ns/1ps
module ext_master_model (
    input  wire logic clk_i,
    input  wire logic want_i,
    input  wire logic bus_grant_n_i,
    output logic      bus_request_n_o
);
    logic grant_q;
    initial begin
        grant_q = 1'b0;
        bus_request_n_o = 1'b1;
    end
    always @(negedge clk_i) begin
        grant_q <= !bus_grant_n_i;
        // a lost grant means refresh is due: yield at once
        if (!want_i || (grant_q && bus_grant_n_i)) begin
            bus_request_n_o <= 1'b1;
        end else begin
            bus_request_n_o <= 1'b0;
        end
    end
endmodule : ext_master_model

//--- tb/tb.sv
// testbench for the bus release arbiter
`timescale 1ns/1ps
module tb;
    import bus_release_pkg::*;
    logic clk_i = 0, rst_i = 1, req_n, refr = 0, xfer = 0, cpu = 0;
    logic last = 0, cend = 0, hold = 0, want = 0, g_n, oe_n, s_r;
    owner_t own;
    int n_fail = 0, checks_done = 0, ticks = 0;
    always #20 clk_i = ~clk_i;
    ext_master_model m (.clk_i(clk_i), .want_i(want), .bus_grant_n_i(g_n),
        .bus_request_n_o(req_n));
    external_bus_release_arbiter DUT (.clk_i(clk_i), .rst_i(rst_i),
        .bus_request_in_n_i(req_n), .refresh_req_i(refr), .xfer_req_i(xfer),
        .cpu_req_i(cpu), .cycle_last_state_i(last), .cycle_end_i(cend),
        .group_hold_i(hold), .bus_grant_n_o(g_n), .bus_drive_oe_n_o(oe_n),
        .start_refresh_o(s_r), .start_xfer_o(), .start_cpu_o(),
        .owner_o(own));
    task chk(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task cyc(input logic h);
        @(negedge clk_i) last = 1;
        @(negedge clk_i) begin last = 0; cend = 1; hold = h; end
        @(negedge clk_i) begin cend = 0; hold = 0; end
    endtask : cyc
    // grant must come exactly two edges after the cycle end edge
    task grant_due;
        @(negedge clk_i) chk(g_n, 1);
        @(negedge clk_i) chk(g_n, 0);
        chk(oe_n, 1);
        chk(own, OWN_EXT);
    endtask : grant_due
    task t_refresh;
        refr = 1;
        @(negedge clk_i) chk(g_n, 1);
        want = 0;
        repeat (12) @(negedge clk_i) if (s_r === 1'b1) break;
        chk(s_r, 1);
        refr = 0;
        repeat (3) @(negedge clk_i);
        chk(oe_n, 0);
    endtask : t_refresh
    task t_group;
        want = 1;
        repeat (5) @(negedge clk_i);
        cyc(1);
        repeat (3) @(negedge clk_i) chk(g_n, 1);
        cyc(0);
        grant_due();
        t_refresh();
    endtask : t_group
    task t_late;
        @(negedge clk_i) last = 1;
        @(negedge clk_i) begin last = 0; cend = 1; want = 1; end
        @(negedge clk_i) cend = 0;
        repeat (3) @(negedge clk_i) chk(g_n, 1);
        cyc(0);
        grant_due();
        t_refresh();
    endtask : t_late
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 3000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 0;
        chk(g_n, 1);
        chk(oe_n, 0);
        cpu = 1;
        repeat (3) @(negedge clk_i);
        t_group();
        t_late();
        conclude();
    end
endmodule : tb
